// *** include/txsip_map.svh ***
`ifndef TXSIP_MAP_SVH
`define TXSIP_MAP_SVH
// Behaviour
// - In DS3/E3 framed modes without overhead mask, a frame-align edge restarts the frame.
// - In fractional modes a rising edge on the frame-align pin restarts the frame position.
// - The align pin may stay high or low; without an edge the current framing continues.
// - Inputs are sampled on the rising reference edge, or the falling one when inverted.
// - The reference clock is one of tx clock in, tx line, tx clock out, rx clock out, rx line.
// - Each transmit input pin except the PLCP overhead clock has its own polarity inversion before it is interpreted.
// - In mask modes a low mask marks a bit that leaves three periods later, mask alike.
// - In flexible fractional mode the payload comes from the serial pin.
// - In PLCP modes with the port on, active enable replaces overhead with the input bit.
// - The PLCP frame-start output marks the first bit of the overhead sequence.
// - The PLCP overhead input is taken on the falling edge of the PLCP overhead clock.
// - In internal or external fractional modes the serial pin carries fractional overhead.
// - The PLCP enable, taken on the PLCP clock falling edge, selects the replaced bits.

// Register byte offsets
`define TXSIP_CTRL_OFS   8'h00
`define TXSIP_FLEN_OFS   8'h04
`define TXSIP_PLEN_OFS   8'h08
`define TXSIP_STAT_OFS   8'h0c

// Control field positions
`define TXSIP_MODE_LSB   0
`define TXSIP_MODE_MSB   3
`define TXSIP_CSEL_LSB   4
`define TXSIP_CSEL_MSB   6
`define TXSIP_CINV_BIT   7
`define TXSIP_EN_BIT     8
`define TXSIP_IALN_BIT   9
`define TXSIP_ISER_BIT   10
`define TXSIP_IPOH_BIT   11
`define TXSIP_IPEN_BIT   12
`define TXSIP_FILL_BIT   13
`define TXSIP_CTRL_MSB   13

// Reset values
`define TXSIP_CTRL_RST   14'h0000
`define TXSIP_FLEN_RST   16'h0100
`define TXSIP_PLEN_RST   16'h0030

// Delay from mask input to mask and data output, in reference clocks
`define TXSIP_MASK_DLY   3
`endif

// *** include/txsip_pkg.sv ***
package txsip_pkg;
   typedef enum logic [3:0] {
      txsip_m_cc,
      txsip_m_ds3,
      txsip_m_e3,
      txsip_m_ds3_ohm,
      txsip_m_e3_ohm,
      txsip_m_ds3_plcp,
      txsip_m_e3_plcp,
      txsip_m_frac_int,
      txsip_m_frac_ext,
      txsip_m_flex
   } txsip_mode_t;

   typedef enum logic [2:0] {
      txsip_c_tx_in,
      txsip_c_tx_line,
      txsip_c_tx_out,
      txsip_c_rx_out,
      txsip_c_rx_line
   } txsip_csel_t;
endpackage : txsip_pkg

// *** include/txsip_sync_if.sv ***
`timescale 1ns/100ps
interface txsip_sync_if #(parameter int W = 1);
   logic [W-1:0] raw;
   logic [W-1:0] agreed;
   modport sync (input raw, output agreed);
   modport user (output raw, input agreed);
endinterface : txsip_sync_if

// *** rtl/txsip_sync.sv ***
`timescale 1ns/100ps
module txsip_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic   clk,
   input wire logic   rst_n,
   // Crossing
   txsip_sync_if.sync port
);
   import txsip_pkg::*;

   logic [W-1:0] s1_ff;
   logic [W-1:0] s2_ff;
   logic [W-1:0] s3_ff;
   logic [W-1:0] q_ff;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
      end else begin
         s1_ff <= port.raw;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   // A change only counts once two late stages agree
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q_ff <= '0;
      end else begin
         for (int i = 0; i < W; i++) begin
            if (s2_ff[i] == s3_ff[i]) begin
               q_ff[i] <= s3_ff[i];
            end
         end
      end
   end

   assign port.agreed = q_ff;
endmodule : txsip_sync

// *** rtl/txsip_top.sv ***
`timescale 1ns/100ps
`include "txsip_map.svh"
module txsip_top (
   // AHB-Lite slave
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Reference clock candidates
   input  wire logic        tx_clock_in,
   input  wire logic        tx_line_clock,
   input  wire logic        tx_clock_out,
   input  wire logic        rx_clock_out,
   input  wire logic        rx_line_clock,
   // Shared serial input pins
   input  wire logic        tx_frame_align_in,
   input  wire logic        tx_serial_payload_in,
   input  wire logic        tx_plcp_overhead_clock,
   input  wire logic        tx_plcp_overhead_enable,
   // Serial outputs
   output logic             tx_line_data_out,
   output logic             tx_overhead_mask_out,
   output logic             tx_plcp_overhead_frame_start
);
   import txsip_pkg::*;

   function automatic logic f_ohm(input txsip_mode_t m);
      f_ohm = (m == txsip_m_ds3_ohm) || (m == txsip_m_e3_ohm);
   endfunction : f_ohm

   function automatic logic f_plcp(input txsip_mode_t m);
      f_plcp = (m == txsip_m_ds3_plcp) || (m == txsip_m_e3_plcp);
   endfunction : f_plcp

   function automatic logic f_frac(input txsip_mode_t m);
      f_frac = (m == txsip_m_frac_int) || (m == txsip_m_frac_ext) || (m == txsip_m_flex);
   endfunction : f_frac

   function automatic logic f_align(input txsip_mode_t m);
      case (m)
         txsip_m_ds3, txsip_m_e3, txsip_m_ds3_plcp, txsip_m_e3_plcp: f_align = 1'b1;
         default: f_align = f_frac(m);
      endcase
   endfunction : f_align

   // Bus-side registers
   logic [`TXSIP_CTRL_MSB:0] ctrl_ff;
   logic [15:0]              flen_ff;
   logic [15:0]              plen_ff;
   logic                     wr_pend_ff;
   logic [7:0]               waddr_ff;
   logic [31:0]              hrdata_ff;
   logic                     hreadyout_ff;
   logic                     hresp_ff;
   logic [7:0]               aln_cnt_ff;
   logic [7:0]               frm_cnt_ff;
   logic [1:0]               tgl_prev_ff;
   logic                     acc;

   // Link-side registers
   logic                     ref_raw;
   logic                     ref_clk;
   logic                     lrst_a_ff;
   logic                     lrst_n_ff;
   txsip_mode_t              mode_lk_ff;
   logic [3:0]               inv_lk_ff;
   logic                     fill_lk_ff;
   logic [15:0]              flen_lk_ff;
   logic [15:0]              plen_lk_ff;
   logic                     aln_ff;
   logic                     aln_prev_ff;
   logic [15:0]              bit_cnt_ff;
   logic                     aln_tgl_ff;
   logic                     frm_tgl_ff;
   logic [2:0]               dat_dly_ff;
   logic [2:0]               msk_dly_ff;
   logic                     pclk_prev_ff;
   logic [15:0]              plcp_cnt_ff;
   logic                     poh_bit_ff;
   logic                     poh_en_ff;
   logic                     sof_ff;
   logic                     en_lk;
   logic                     align_rise;
   logic                     plcp_fall;
   logic                     mask_now;
   logic                     ser_now;
   logic                     nxt_dat;
   logic                     nxt_msk;

   txsip_sync_if #(.W(1)) en_if ();
   txsip_sync_if #(.W(3)) poh_if ();
   txsip_sync_if #(.W(3)) st_if ();

   // Bus slave: zero wait states, always OKAY
   assign acc = hsel && htrans[1] && hready;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout_ff <= 1'b1;
         hresp_ff     <= 1'b0;
      end else begin
         hreadyout_ff <= 1'b1;
         hresp_ff     <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_ff <= 1'b0;
         waddr_ff   <= 8'h00;
      end else if (hready) begin
         wr_pend_ff <= acc && hwrite;
         waddr_ff   <= haddr[7:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_ff <= `TXSIP_CTRL_RST;
         flen_ff <= `TXSIP_FLEN_RST;
         plen_ff <= `TXSIP_PLEN_RST;
      end else if (wr_pend_ff) begin
         case (waddr_ff)
            `TXSIP_CTRL_OFS: ctrl_ff <= hwdata[`TXSIP_CTRL_MSB:0];
            `TXSIP_FLEN_OFS: flen_ff <= hwdata[15:0];
            `TXSIP_PLEN_OFS: plen_ff <= hwdata[15:0];
            default: ;
         endcase
      end
   end

   // Read data is registered at the address phase edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_ff <= 32'h0000_0000;
      end else if (acc && !hwrite) begin
         case (haddr[7:0])
            `TXSIP_CTRL_OFS: hrdata_ff <= {18'h00000, ctrl_ff};
            `TXSIP_FLEN_OFS: hrdata_ff <= {16'h0000, flen_ff};
            `TXSIP_PLEN_OFS: hrdata_ff <= {16'h0000, plen_ff};
            `TXSIP_STAT_OFS: hrdata_ff <= {15'h0000, st_if.agreed[2], frm_cnt_ff, aln_cnt_ff};
            default:         hrdata_ff <= 32'h0000_0000;
         endcase
      end
   end

   // Link events arrive as toggles and are counted on the bus side
   assign st_if.raw = {en_lk, frm_tgl_ff, aln_tgl_ff};

   txsip_sync #(.W(3)) u_st_sync (
      .clk   (hclk),
      .rst_n (hresetn),
      .port  (st_if.sync)
   );

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tgl_prev_ff <= 2'b00;
         aln_cnt_ff  <= 8'h00;
         frm_cnt_ff  <= 8'h00;
      end else begin
         tgl_prev_ff <= st_if.agreed[1:0];
         if (st_if.agreed[0] != tgl_prev_ff[0]) begin
            aln_cnt_ff <= aln_cnt_ff + 8'h01;
         end
         if (st_if.agreed[1] != tgl_prev_ff[1]) begin
            frm_cnt_ff <= frm_cnt_ff + 8'h01;
         end
      end
   end

   // Select is static: change it only while the port is disabled, else the mux may glitch
   always_comb begin
      case (txsip_csel_t'(ctrl_ff[`TXSIP_CSEL_MSB:`TXSIP_CSEL_LSB]))
         txsip_c_tx_line: ref_raw = tx_line_clock;
         txsip_c_tx_out:  ref_raw = tx_clock_out;
         txsip_c_rx_out:  ref_raw = rx_clock_out;
         txsip_c_rx_line: ref_raw = rx_line_clock;
         default:         ref_raw = tx_clock_in;
      endcase
   end

   // Inverting the clock moves sampling to its falling edge
   assign ref_clk = ref_raw ^ ctrl_ff[`TXSIP_CINV_BIT];

   always_ff @(posedge ref_clk or negedge hresetn) begin
      if (!hresetn) begin
         lrst_a_ff <= 1'b0;
         lrst_n_ff <= 1'b0;
      end else begin
         lrst_a_ff <= 1'b1;
         lrst_n_ff <= lrst_a_ff;
      end
   end

   assign en_if.raw = ctrl_ff[`TXSIP_EN_BIT];

   txsip_sync #(.W(1)) u_en_sync (
      .clk   (ref_clk),
      .rst_n (lrst_n_ff),
      .port  (en_if.sync)
   );

   assign en_lk = en_if.agreed[0];

   // Settings are taken over only while the port is off, so they cross as stable words
   always_ff @(posedge ref_clk or negedge lrst_n_ff) begin
      if (!lrst_n_ff) begin
         mode_lk_ff <= txsip_m_cc;
         inv_lk_ff  <= 4'h0;
         fill_lk_ff <= 1'b0;
         flen_lk_ff <= `TXSIP_FLEN_RST;
         plen_lk_ff <= `TXSIP_PLEN_RST;
      end else if (!en_lk) begin
         mode_lk_ff <= txsip_mode_t'(ctrl_ff[`TXSIP_MODE_MSB:`TXSIP_MODE_LSB]);
         inv_lk_ff  <= ctrl_ff[`TXSIP_IPEN_BIT:`TXSIP_IALN_BIT];
         fill_lk_ff <= ctrl_ff[`TXSIP_FILL_BIT];
         flen_lk_ff <= flen_ff;
         plen_lk_ff <= plen_ff;
      end
   end

   assign mask_now = tx_frame_align_in ^ inv_lk_ff[0];
   assign ser_now  = tx_serial_payload_in ^ inv_lk_ff[1];

   always_ff @(posedge ref_clk or negedge lrst_n_ff) begin
      if (!lrst_n_ff) begin
         aln_ff      <= 1'b0;
         aln_prev_ff <= 1'b0;
      end else begin
         aln_ff      <= mask_now;
         aln_prev_ff <= aln_ff;
      end
   end

   assign align_rise = en_lk && f_align(mode_lk_ff) && aln_ff && !aln_prev_ff;

   // A level held high or low yields no edge, so the frame just free-runs
   always_ff @(posedge ref_clk or negedge lrst_n_ff) begin
      if (!lrst_n_ff) begin
         bit_cnt_ff <= 16'h0000;
         aln_tgl_ff <= 1'b0;
         frm_tgl_ff <= 1'b0;
      end else if (!en_lk) begin
         bit_cnt_ff <= 16'h0000;
      end else if (align_rise) begin
         bit_cnt_ff <= 16'h0000;
         aln_tgl_ff <= !aln_tgl_ff;
      end else if (bit_cnt_ff >= flen_lk_ff - 16'h0001) begin
         bit_cnt_ff <= 16'h0000;
         frm_tgl_ff <= !frm_tgl_ff;
      end else begin
         bit_cnt_ff <= bit_cnt_ff + 16'h0001;
      end
   end

   // PLCP clock is slow and foreign: oversample it with its data and enable
   assign poh_if.raw = {tx_plcp_overhead_enable, tx_serial_payload_in, tx_plcp_overhead_clock};

   txsip_sync #(.W(3)) u_poh_sync (
      .clk   (ref_clk),
      .rst_n (lrst_n_ff),
      .port  (poh_if.sync)
   );

   assign plcp_fall = pclk_prev_ff && !poh_if.agreed[0];

   always_ff @(posedge ref_clk or negedge lrst_n_ff) begin
      if (!lrst_n_ff) begin
         pclk_prev_ff <= 1'b0;
      end else begin
         pclk_prev_ff <= poh_if.agreed[0];
      end
   end

   always_ff @(posedge ref_clk or negedge lrst_n_ff) begin
      if (!lrst_n_ff) begin
         plcp_cnt_ff <= 16'h0000;
         poh_bit_ff  <= 1'b0;
         poh_en_ff   <= 1'b0;
         sof_ff      <= 1'b0;
      end else if (!en_lk || !f_plcp(mode_lk_ff)) begin
         plcp_cnt_ff <= 16'h0000;
         poh_en_ff   <= 1'b0;
         sof_ff      <= 1'b0;
      end else if (plcp_fall) begin
         poh_bit_ff <= poh_if.agreed[1] ^ inv_lk_ff[2];
         poh_en_ff  <= poh_if.agreed[2] ^ inv_lk_ff[3];
         if (plcp_cnt_ff >= plen_lk_ff - 16'h0001) begin
            plcp_cnt_ff <= 16'h0000;
            sof_ff      <= 1'b1;
         end else begin
            plcp_cnt_ff <= plcp_cnt_ff + 16'h0001;
            sof_ff      <= 1'b0;
         end
      end
   end

   // Line data source follows the mode; other pin functions are dropped
   always_comb begin
      nxt_dat = fill_lk_ff;
      nxt_msk = 1'b0;
      if (en_lk) begin
         if (mode_lk_ff == txsip_m_flex) begin
            nxt_dat = ser_now;
         end else if (f_frac(mode_lk_ff)) begin
            nxt_dat = ser_now;
         end else if (f_plcp(mode_lk_ff) && poh_en_ff) begin
            nxt_dat = poh_bit_ff;
         end else if (f_ohm(mode_lk_ff)) begin
            nxt_msk = mask_now;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge lrst_n_ff) begin
      if (!lrst_n_ff) begin
         dat_dly_ff <= 3'h0;
         msk_dly_ff <= 3'h0;
      end else begin
         dat_dly_ff <= {dat_dly_ff[1:0], nxt_dat};
         msk_dly_ff <= {msk_dly_ff[1:0], nxt_msk};
      end
   end

   assign tx_line_data_out             = dat_dly_ff[`TXSIP_MASK_DLY-1];
   assign tx_overhead_mask_out         = msk_dly_ff[`TXSIP_MASK_DLY-1];
   assign tx_plcp_overhead_frame_start = sof_ff;
   assign hrdata                       = hrdata_ff;
   assign hreadyout                    = hreadyout_ff;
   assign hresp                        = hresp_ff;

   property p_align_restart;
      @(posedge ref_clk) disable iff (!lrst_n_ff)
      (align_rise && !f_frac(mode_lk_ff)) |=> (bit_cnt_ff == 16'h0000);
   endproperty
   a_align_restart: assert property (p_align_restart) else $error("align ignored");

   property p_frac_restart;
      @(posedge ref_clk) disable iff (!lrst_n_ff)
      (en_lk && f_frac(mode_lk_ff) && aln_ff && !aln_prev_ff) |=> (bit_cnt_ff == 16'h0000);
   endproperty
   a_frac_restart: assert property (p_frac_restart) else $error("frac align lost");

   property p_hold_frame;
      @(posedge ref_clk) disable iff (!lrst_n_ff)
      (en_lk && !align_rise && (bit_cnt_ff < flen_lk_ff - 16'h0001))
         |=> (bit_cnt_ff == $past(bit_cnt_ff) + 16'h0001);
   endproperty
   a_hold_frame: assert property (p_hold_frame) else $error("frame moved");

   property p_mask_delay;
      @(posedge ref_clk) disable iff (!lrst_n_ff)
      (en_lk && f_ohm(mode_lk_ff)) ##1 (en_lk && f_ohm(mode_lk_ff)) [*2]
         |=> (tx_overhead_mask_out == $past(mask_now, 3));
   endproperty
   a_mask_delay: assert property (p_mask_delay) else $error("mask delay not three");

   property p_flex_data;
      @(posedge ref_clk) disable iff (!lrst_n_ff)
      (en_lk && mode_lk_ff == txsip_m_flex) [*3]
         |=> (tx_line_data_out == $past(tx_serial_payload_in ^ inv_lk_ff[1], 3));
   endproperty
   a_flex_data: assert property (p_flex_data) else $error("payload wrong");

   property p_frac_oh;
      @(posedge ref_clk) disable iff (!lrst_n_ff)
      (en_lk && (mode_lk_ff == txsip_m_frac_int || mode_lk_ff == txsip_m_frac_ext)) [*3]
         |=> (tx_line_data_out == $past(ser_now, 3));
   endproperty
   a_frac_oh: assert property (p_frac_oh) else $error("fractional overhead lost");

   property p_plcp_replace;
      @(posedge ref_clk) disable iff (!lrst_n_ff)
      (en_lk && f_plcp(mode_lk_ff) && poh_en_ff && !plcp_fall) [*3]
         |=> (tx_line_data_out == poh_bit_ff);
   endproperty
   a_plcp_replace: assert property (p_plcp_replace) else $error("no replace");

   property p_plcp_sof;
      @(posedge ref_clk) disable iff (!lrst_n_ff)
      (en_lk && f_plcp(mode_lk_ff) && plcp_fall && plcp_cnt_ff >= plen_lk_ff - 16'h0001)
         |=> (tx_plcp_overhead_frame_start && plcp_cnt_ff == 16'h0000);
   endproperty
   a_plcp_sof: assert property (p_plcp_sof) else $error("PLCP start mark missing");

   property p_plcp_hold;
      @(posedge ref_clk) disable iff (!lrst_n_ff)
      (f_plcp(mode_lk_ff) && en_lk && !plcp_fall) |=> $stable(poh_bit_ff);
   endproperty
   a_plcp_hold: assert property (p_plcp_hold) else $error("PLCP bit taken off edge");

   property p_route;
      @(posedge ref_clk) disable iff (!lrst_n_ff)
      (!f_ohm(mode_lk_ff)) [*4] |-> !tx_overhead_mask_out;
   endproperty
   a_route: assert property (p_route) else $error("mask output outside mask mode");

   property p_ahb_ok;
      @(posedge hclk) disable iff (!hresetn)
      acc |=> (hreadyout && !hresp);
   endproperty
   a_ahb_ok: assert property (p_ahb_ok) else $error("bus answer not OKAY");
endmodule : txsip_top

// *** sim/txsip_src.sv ***
`timescale 1ns/100ps
module txsip_src (
   // Bench control
   input  wire logic [2:0] sel,
   input  wire logic       inv,
   input  wire logic [1:0] amode,
   input  wire logic       slow,
   // Pins toward the port
   output logic [4:0]      clks,
   output logic            rclk,
   output logic            align,
   output logic            ser,
   output logic            pclk,
   output logic            pen
);
   logic        ck      = 1'b0;
   logic [15:0] lfsr_ff = 16'hace1;
   logic [4:0]  pcnt_ff = 5'h00;
   initial {align, ser, pclk, pen} = 4'h0;
   // Slower than line rate; the port only cares about the edges it samples
   initial #3 forever #15 ck = ~ck;
   // Unselected candidates stand still, so a wrong select shows as dead data
   assign clks = {5{ck}} & (5'h01 << sel);
   assign rclk = ck ^ inv;
   always @(posedge rclk) begin
      lfsr_ff <= {lfsr_ff[14:0], lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10]};
      pcnt_ff <= (pcnt_ff == 5'h0b) ? 5'h00 : pcnt_ff + 5'h01;
      if (pcnt_ff == 5'h0b) begin
         pclk <= ~pclk;
      end
      // Overhead bits held a whole PLCP period, so they are stable at the fall
      if (!slow) begin
         ser <= lfsr_ff[0];
      end else if (pcnt_ff == 5'h0b && !pclk) begin
         ser <= lfsr_ff[0];
         pen <= lfsr_ff[1];
      end
      case (amode)
         2'd0: align <= 1'b0;
         2'd1: align <= 1'b1;
         2'd2: align <= pcnt_ff[2];
         default: align <= lfsr_ff[3];
      endcase
   end
endmodule : txsip_src

// *** sim/txsip_top_tb.sv ***
`timescale 1ns/100ps
module txsip_top_tb;
   import txsip_pkg::*;
`define TB_CHK(a, e) begin checked++; if ((a) !== (e)) begin miscompares++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
   logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [1:0]  htrans = 2'b00, amode = 2'b00;
   logic [2:0]  hsize = 3'b010, sel = 3'h0, hs = 3'h0, ha = 3'h0;
   logic        inv = 1'b0, slow = 1'b0, aprev = 1'b0;
   logic [31:0] cur = 32'h0;
   logic        hreadyout, hresp, line, mko, fso, rclk, align, ser, pclk, pen;
   logic [4:0]  clks;
   int          miscompares = 0, checked = 0, rises = 0;
   always #5 hclk = ~hclk;
   always @(posedge rclk) begin
      hs <= {hs[1:0], ser};
      ha <= {ha[1:0], align};
      aprev <= align;
      if (align && !aprev) rises++;
   end
   txsip_src u_txsip_src (.sel(sel), .inv(inv), .amode(amode), .slow(slow), .clks(clks),
      .rclk(rclk), .align(align), .ser(ser), .pclk(pclk), .pen(pen));
   txsip_top u_txsip_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .tx_clock_in(clks[0]),
      .tx_line_clock(clks[1]), .tx_clock_out(clks[2]), .rx_clock_out(clks[3]),
      .rx_line_clock(clks[4]), .tx_frame_align_in(align), .tx_serial_payload_in(ser),
      .tx_plcp_overhead_clock(pclk), .tx_plcp_overhead_enable(pen),
      .tx_line_data_out(line), .tx_overhead_mask_out(mko),
      .tx_plcp_overhead_frame_start(fso));
   task automatic final_report;
      $display("checked=%0d miscompares=%0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : final_report
   task automatic wt;
      int n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 64);
      if (n >= 64) begin
         miscompares++;
         final_report();
      end
   endtask : wt
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= w;
      wt();
      htrans <= 2'b00;
      hwdata <= wd;
      wt();
      rd = hrdata;
      hsel <= 1'b0;
   endtask : bus
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      `TB_CHK({hresp, rd}, {1'b0, e})
   endtask : rdchk
   task automatic rw(input int n);
      repeat (n) @(posedge rclk);
   endtask : rw
   // Mode fields are only taken while the link is disabled and the clock mux follows its field at once, so the
   // old setting is switched off first and only then is the clock moved
   task automatic cfg(input logic [31:0] c);
      bus(1'b1, 8'h00, cur & 32'hfffffeff);
      rw(12);
      bus(1'b1, 8'h00, c & 32'hfffffeff);
      sel <= c[6:4];
      inv <= c[7];
      rw(12);
      bus(1'b1, 8'h00, c | 32'h100);
      cur = c | 32'h100;
      rw(16);
   endtask : cfg
   task automatic t_regs;
      rdchk(8'h00, 32'h0);
      rdchk(8'h04, 32'h100);
      rdchk(8'h08, 32'h30);
      bus(1'b1, 8'h20, 32'hffffffff);
      rdchk(8'h20, 32'h0);
      bus(1'b1, 8'h0c, 32'hffffffff);
      rdchk(8'h0c, 32'h0);
      bus(1'b1, 8'h04, 32'hffff1234);
      rdchk(8'h04, 32'h1234);
      bus(1'b1, 8'h04, 32'h100);
      $display("test regs done");
   endtask : t_regs
   task automatic t_flex;
      logic [31:0] c;
      for (int i = 0; i < 6; i++) begin
         c = 32'(txsip_m_flex) | 32'((i % 5) << 4) | 32'((i / 5) << 7) | 32'((i % 2) << 10);
         cfg(c);
         for (int k = 0; k < 24; k++) begin
            @(negedge rclk);
            `TB_CHK(line, hs[2] ^ c[10])
            `TB_CHK(mko, 1'b0)
         end
      end
      $display("test flex done");
   endtask : t_flex
   task automatic t_mask;
      logic [31:0] c;
      amode <= 2'd3;
      for (int i = 0; i < 2; i++) begin
         c = 32'(i ? txsip_m_e3_ohm : txsip_m_ds3_ohm) | 32'h2000 | 32'(i << 9);
         cfg(c);
         for (int k = 0; k < 24; k++) begin
            @(negedge rclk);
            `TB_CHK(mko, ha[2] ^ c[9])
            `TB_CHK(line, 1'b1)
         end
      end
      $display("test mask done");
   endtask : t_mask
   task automatic t_align;
      txsip_mode_t md[4] = '{txsip_m_ds3, txsip_m_e3, txsip_m_frac_int, txsip_m_frac_ext};
      logic [7:0] s0;
      int r0;
      for (int i = 0; i < 4; i++) begin
         amode <= 2'd0;
         cfg(32'(md[i]));
         bus(1'b0, 8'h0c, 32'h0);
         s0 = rd[7:0];
         r0 = rises;
         amode <= 2'd2;
         rw(40);
         amode <= 2'd1;
         rw(12);
         s0 = s0 + 8'(rises - r0);
         bus(1'b0, 8'h0c, 32'h0);
         `TB_CHK(rd[7:0], s0)
         rw(20);
         bus(1'b0, 8'h0c, 32'h0);
         `TB_CHK(rd[7:0], s0)
      end
      $display("test align done");
   endtask : t_align
   task automatic t_plcp;
      logic [7:0] fs;
      logic xd;
      slow <= 1'b1;
      for (int i = 0; i < 2; i++) begin
         bus(1'b1, 8'h08, 32'h4);
         cfg(32'(i ? txsip_m_e3_plcp : txsip_m_ds3_plcp) | 32'h2000);
         fs = 8'h0;
         xd = 1'b1;
         for (int k = 0; k < 13; k++) begin
            @(negedge pclk);
            if (k > 0) `TB_CHK(line, xd)
            if (k > 0) fs = fs + 8'(fso);
            xd = pen ? ser : 1'b1;
         end
         `TB_CHK(fs, 8'h03)
      end
      slow <= 1'b0;
      $display("test plcp done");
   endtask : t_plcp
   initial begin
      #500us;
      miscompares++;
      final_report();
   end
   initial begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      t_regs();
      t_flex();
      t_mask();
      t_align();
      t_plcp();
      final_report();
   end
endmodule : txsip_top_tb
